// *** src/uml_modem_line_status_flow.sv ***
// Purpose: modem control, line status, modem status, scratch and hardware flow control
// Assumes: receiver, transmitter and fifo logic run on core_clk; pins are asynchronous
// Notes: all state lives in one struct, filled by one comb process and one flop process
`timescale 1ns/1ps
`default_nettype none

module uml_modem_line_status_flow (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cts_n_pin,
	input wire logic dsr_n_pin,
	input wire logic cd_n_pin,
	input wire logic ri_n_pin,
	input wire logic rx_pin,
	output logic rts_n_pin,
	output logic dtr_n_pin,
	output logic op2_n_pin,
	output logic tx_pin,
	output logic int_oe,
	input wire logic [3:0] interrupt_enable_reg,
	input wire logic tx_serial,
	output logic rx_serial,
	output logic baud_tick,
	input wire logic tx_hold_moved,
	input wire logic tx_fifo_emptied,
	input wire logic tx_host_load,
	input wire logic tx_shift_empty,
	output logic tx_stop,
	input wire logic [5:0] rx_fifo_level,
	input wire uml_pkg::uml_rx_flags_type rx_top_flags,
	input wire logic rx_fifo_any_err,
	input wire logic rx_char_done,
	input wire logic rx_break_frame,
	output logic rx_push,
	output logic rx_push_brk,
	output logic int_thr_req,
	output logic int_msr_req,
	output logic int_rx_trig_req
);
	import uml_pkg::*;

	// trigger level chosen by the two-bit code
	function automatic logic [5:0] trig_level(input logic [1:0] code);
		case (code)
			2'h0: trig_level = TRIG_L0;
			2'h1: trig_level = TRIG_L1;
			2'h2: trig_level = TRIG_L2;
			default: trig_level = TRIG_L3;
		endcase
	endfunction

	// level one step above the programmed trigger, where RTS is raised
	function automatic logic [5:0] trig_upper(input logic [1:0] code);
		case (code)
			2'h0: trig_upper = TRIG_L1;
			2'h1: trig_upper = TRIG_L2;
			2'h2: trig_upper = TRIG_L3;
			default: trig_upper = RX_DEPTH;
		endcase
	endfunction

	// level one step below the programmed trigger, where RTS drops again
	function automatic logic [5:0] trig_lower(input logic [1:0] code);
		case (code)
			2'h0: trig_lower = TRIG_LOW0;
			2'h1: trig_lower = TRIG_L0;
			2'h2: trig_lower = TRIG_L1;
			default: trig_lower = TRIG_L2;
		endcase
	endfunction

	uml_state_type cur;
	uml_state_type next_state;
	uml_modem_type pin_state;
	uml_modem_type loop_state;
	uml_modem_type modem_now;
	uml_rx_flags_type top_flags;
	logic loop_on;
	logic fifo_mode;
	logic [1:0] trig_code;
	logic rx_full;
	logic data_ready;
	logic [7:0] line_status;
	logic [7:0] modem_status;
	logic [3:0] delta_set;
	logic wr_mc;
	logic rd_ls;
	logic rd_ms;

	// next state of the whole block
	always_comb begin
		next_state = cur;
		loop_on = cur.modem_control_reg[MC_LOOP];
		fifo_mode = cur.fifo_control_reg[FC_ENABLE];
		trig_code = cur.fifo_control_reg[FC_TRIG_LSB +: 2];
		wr_mc = reg_wr && (reg_addr == OFS_MODEM_CTRL);
		rd_ls = reg_rd && (reg_addr == OFS_LINE_STATUS);
		rd_ms = reg_rd && (reg_addr == OFS_MODEM_STATUS);

		// two-flop synchronisers: rx, cd, ri, dsr, cts
		next_state.pin_s1 = {rx_pin, cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};
		next_state.pin_s2 = cur.pin_s1;

		// modem inputs as seen by status logic
		pin_state = uml_modem_type'(~cur.pin_s2[3:0]);
		loop_state.cd = cur.modem_control_reg[MC_OUT2];
		loop_state.ri = cur.modem_control_reg[MC_OUT1];
		loop_state.dsr = cur.modem_control_reg[MC_DTR];
		loop_state.cts = cur.modem_control_reg[MC_RTS];
		modem_now = loop_on ? loop_state : pin_state;
		next_state.modem_prev = modem_now;

		// change detection; ring only on pin low-to-high, i.e. active bit falling
		delta_set[3] = modem_now.cd ^ cur.modem_prev.cd;
		delta_set[2] = cur.modem_prev.ri && !modem_now.ri;
		delta_set[1] = modem_now.dsr ^ cur.modem_prev.dsr;
		delta_set[0] = modem_now.cts ^ cur.modem_prev.cts;
		// a read clears the change bits, a change in the same cycle wins
		next_state.delta = (rd_ms ? 4'h0 : cur.delta) | delta_set;
		modem_status = {modem_now, cur.delta};

		// receive fifo view
		rx_full = rx_fifo_level >= (fifo_mode ? RX_DEPTH : RX_DEPTH_NOFIFO);
		data_ready = rx_fifo_level != 6'h00;
		top_flags = data_ready ? rx_top_flags : uml_rx_flags_type'(3'h0);

		// break char pushed once per break unless the fifo is full, re-armed when the line idles high
		next_state.rx_push_brk = 1'b0;
		case (cur.brk_state)
			BRK_IDLE: begin
				if (rx_break_frame) begin
					next_state.rx_push_brk = !rx_full;
					next_state.brk_state = BRK_HELD;
				end
			end
			BRK_HELD: begin
				if (cur.pin_s2[4]) begin
					next_state.brk_state = BRK_IDLE;
				end
			end
			default: begin
				next_state.brk_state = BRK_IDLE;
			end
		endcase

		// normal char push, withheld when the fifo is full
		next_state.rx_push = rx_char_done && !rx_full;
		next_state.overrun = (rd_ls ? 1'b0 : cur.overrun) || (rx_char_done && rx_full);

		// holding-empty flag; a set in the cycle of a host load wins
		next_state.thre = (tx_host_load ? 1'b0 : cur.thre) || tx_hold_moved
			|| (fifo_mode && tx_fifo_emptied);

		line_status = {fifo_mode && rx_fifo_any_err,
			cur.thre && tx_shift_empty,
			cur.thre, top_flags.brk, top_flags.frm, top_flags.par,
			cur.overrun, data_ready};

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				OFS_SCRATCH: next_state.scratch_reg = reg_wdata;
				OFS_MODEM_CTRL: next_state.modem_control_reg = reg_wdata & MC_WRITE_MASK;
				OFS_ENH_FEATURE: next_state.enhanced_feature_reg = reg_wdata;
				OFS_FIFO_CTRL: next_state.fifo_control_reg = reg_wdata & FC_WRITE_MASK;
				default: begin
				end
			endcase
		end

		// read data, valid the cycle after the strobe only
		next_state.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				OFS_SCRATCH: next_state.rdata = cur.scratch_reg;
				OFS_MODEM_CTRL: next_state.rdata = cur.modem_control_reg;
				OFS_LINE_STATUS: next_state.rdata = line_status;
				OFS_MODEM_STATUS: next_state.rdata = modem_status;
				OFS_ENH_FEATURE: next_state.rdata = cur.enhanced_feature_reg;
				OFS_FIFO_CTRL: next_state.rdata = cur.fifo_control_reg;
				default: next_state.rdata = 8'h00;
			endcase
		end

		// prescaler: tick every cycle, or every fourth cycle when selected
		if (!cur.modem_control_reg[MC_CLK_SEL] || cur.div_cnt == DIV_LAST) begin
			next_state.div_cnt = 2'h0;
		end else begin
			next_state.div_cnt = cur.div_cnt + 2'h1;
		end
		next_state.baud_tick = !cur.modem_control_reg[MC_CLK_SEL]
			|| cur.div_cnt == DIV_LAST;
		if (wr_mc) begin
			next_state.div_cnt = 2'h0; // restart the divider on a control write
		end

		// auto RTS hysteresis between the upper and lower levels
		if (!cur.enhanced_feature_reg[EF_AUTO_RTS]) begin
			next_state.rts_hold = 1'b0;
		end else if (rx_fifo_level >= trig_upper(trig_code)) begin
			next_state.rts_hold = 1'b1;
		end else if (rx_fifo_level < trig_lower(trig_code)) begin
			next_state.rts_hold = 1'b0;
		end
		next_state.int_rx_trig = fifo_mode
			&& rx_fifo_level >= trig_level(trig_code);

		// modem outputs; RTS and DTR parked inactive in loop-back, OUT2 and the output enable still follow the register
		next_state.rts_n = loop_on || !(cur.modem_control_reg[MC_RTS]
			&& !cur.rts_hold);
		next_state.dtr_n = loop_on || !cur.modem_control_reg[MC_DTR];
		next_state.op2_n = !cur.modem_control_reg[MC_OUT2];
		next_state.int_oe = cur.modem_control_reg[MC_OUT2];

		// serial path, looped internally in diagnostics mode
		next_state.tx_pin = loop_on || tx_serial;
		next_state.rx_serial = loop_on ? tx_serial : cur.pin_s2[4];

		// transmitter stall from CTS
		next_state.tx_stop = cur.enhanced_feature_reg[EF_AUTO_CTS] && !modem_now.cts;

		// interrupt requests, gated by the enable register
		next_state.int_thr = cur.thre && interrupt_enable_reg[1];
		next_state.int_msr = (cur.delta != 4'h0) && interrupt_enable_reg[3];
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cur.scratch_reg <= RST_REG;
			cur.modem_control_reg <= RST_REG;
			cur.enhanced_feature_reg <= RST_REG;
			cur.fifo_control_reg <= RST_REG;
			cur.pin_s1 <= RST_PINS;
			cur.pin_s2 <= RST_PINS;
			cur.modem_prev <= uml_modem_type'(4'h0);
			cur.delta <= 4'h0;
			cur.overrun <= 1'b0;
			cur.thre <= 1'b1;
			cur.brk_state <= BRK_IDLE;
			cur.div_cnt <= 2'h0;
			cur.rts_hold <= 1'b0;
			cur.rdata <= 8'h00;
			cur.rts_n <= 1'b1;
			cur.dtr_n <= 1'b1;
			cur.op2_n <= 1'b1;
			cur.int_oe <= 1'b0;
			cur.tx_pin <= 1'b1;
			cur.rx_serial <= 1'b1;
			cur.baud_tick <= 1'b0;
			cur.tx_stop <= 1'b0;
			cur.rx_push <= 1'b0;
			cur.rx_push_brk <= 1'b0;
			cur.int_thr <= 1'b0;
			cur.int_msr <= 1'b0;
			cur.int_rx_trig <= 1'b0;
		end else begin
			cur <= next_state;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = cur.rdata;
	assign rts_n_pin = cur.rts_n;
	assign dtr_n_pin = cur.dtr_n;
	assign op2_n_pin = cur.op2_n;
	assign tx_pin = cur.tx_pin;
	assign int_oe = cur.int_oe;
	assign rx_serial = cur.rx_serial;
	assign baud_tick = cur.baud_tick;
	assign tx_stop = cur.tx_stop;
	assign rx_push = cur.rx_push;
	assign rx_push_brk = cur.rx_push_brk;
	assign int_thr_req = cur.int_thr;
	assign int_msr_req = cur.int_msr;
	assign int_rx_trig_req = cur.int_rx_trig;
endmodule

`default_nettype wire

// *** src/uml_pkg.sv ***
// Purpose: shared constants and types for the modem, line status and flow block
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes: register offsets are word indices on a 3-bit register port
package uml_pkg;
	// register offsets
	localparam logic [2:0] OFS_SCRATCH = 3'h0;
	localparam logic [2:0] OFS_MODEM_CTRL = 3'h1;
	localparam logic [2:0] OFS_LINE_STATUS = 3'h2;
	localparam logic [2:0] OFS_MODEM_STATUS = 3'h3;
	localparam logic [2:0] OFS_ENH_FEATURE = 3'h4;
	localparam logic [2:0] OFS_FIFO_CTRL = 3'h5;
	// modem control field positions
	localparam int MC_CLK_SEL = 7;
	localparam int MC_LOOP = 4;
	localparam int MC_OUT2 = 3;
	localparam int MC_OUT1 = 2;
	localparam int MC_RTS = 1;
	localparam int MC_DTR = 0;
	localparam logic [7:0] MC_WRITE_MASK = 8'h9f;
	// enhanced feature and fifo control field positions
	localparam int EF_AUTO_CTS = 7;
	localparam int EF_AUTO_RTS = 6;
	localparam int FC_ENABLE = 0;
	localparam int FC_TRIG_LSB = 6;
	localparam logic [7:0] FC_WRITE_MASK = 8'hc1;
	// reset values
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [4:0] RST_PINS = 5'h1f;
	// receive fifo sizes and trigger table
	localparam logic [5:0] RX_DEPTH = 6'h20;
	localparam logic [5:0] RX_DEPTH_NOFIFO = 6'h01;
	localparam logic [5:0] TRIG_L0 = 6'h08;
	localparam logic [5:0] TRIG_L1 = 6'h10;
	localparam logic [5:0] TRIG_L2 = 6'h18;
	localparam logic [5:0] TRIG_L3 = 6'h1c;
	localparam logic [5:0] TRIG_LOW0 = 6'h04;
	// clock prescaler
	localparam int CLK_DIV = 4;
	localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);

	// modem inputs in active-high form, top bit first
	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} uml_modem_type;

	// per-character receive flags of the fifo top entry
	typedef struct packed {
		logic brk;
		logic frm;
		logic par;
	} uml_rx_flags_type;

	typedef enum logic [1:0] {
		BRK_IDLE = 2'b01,
		BRK_HELD = 2'b10
	} uml_brk_type;

	typedef struct packed {
		logic [7:0] scratch_reg;
		logic [7:0] modem_control_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] fifo_control_reg;
		logic [4:0] pin_s1;
		logic [4:0] pin_s2;
		uml_modem_type modem_prev;
		logic [3:0] delta;
		logic overrun;
		logic thre;
		uml_brk_type brk_state;
		logic [1:0] div_cnt;
		logic rts_hold;
		logic [7:0] rdata;
		logic rts_n;
		logic dtr_n;
		logic op2_n;
		logic int_oe;
		logic tx_pin;
		logic rx_serial;
		logic baud_tick;
		logic tx_stop;
		logic rx_push;
		logic rx_push_brk;
		logic int_thr;
		logic int_msr;
		logic int_rx_trig;
	} uml_state_type;
endpackage

// *** sim/uml_modem_peer.sv ***
// Purpose: modem peer on the handshake and serial lines
// Assumes: the bench sets the peer's handshake levels through set_lines
// Notes: the peer echoes our serial output back onto our serial input
`timescale 1ns/1ps
`default_nettype none
module uml_modem_peer (
	input wire logic core_clk,
	input wire logic [3:0] set_lines,
	input wire logic tx_pin,
	output logic cd_n_pin,
	output logic ri_n_pin,
	output logic dsr_n_pin,
	output logic cts_n_pin,
	output logic rx_pin
);
	logic [4:0] lines_q = 5'h1f;
	assign {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin, rx_pin} = lines_q;
	// pins move just after the edge, as a real peer would
	always @(posedge core_clk) begin
		lines_q <= {set_lines, tx_pin};
	end
endmodule
`default_nettype wire

// *** sim/uml_mlsf_properties.sv ***
// Purpose: port-level checker for the modem, line status and flow block
// Assumes: one clock domain, synchronous active-high reset
// Notes: read answers are judged one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module uml_mlsf_properties (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic dtr_n_pin,
	input wire logic op2_n_pin,
	input wire logic tx_pin,
	input wire logic int_oe,
	input wire logic baud_tick,
	input wire logic [3:0] interrupt_enable_reg,
	input wire logic tx_shift_empty,
	input wire logic [5:0] rx_fifo_level,
	input wire uml_pkg::uml_rx_flags_type rx_top_flags,
	input wire logic rx_fifo_any_err,
	input wire logic rx_char_done,
	input wire logic rx_push,
	input wire logic int_msr_req
);
	import uml_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic mc_wr;
	logic ls_rd;
	// decoded bus cycles
	assign mc_wr = reg_wr && reg_addr == OFS_MODEM_CTRL;
	assign ls_rd = reg_rd && reg_addr == OFS_LINE_STATUS;
	sequence s_div_wr;
		mc_wr && reg_wdata[MC_CLK_SEL] ##1 !mc_wr [*6];
	endsequence
	sequence s_fast_wr;
		mc_wr && !reg_wdata[MC_CLK_SEL] ##1 !mc_wr [*2];
	endsequence
	property p_dtr;
		mc_wr |-> ##2 dtr_n_pin == ($past(reg_wdata[MC_LOOP], 2) | !$past(reg_wdata[MC_DTR], 2));
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr pin wrong after write");
	property p_oe;
		mc_wr |-> ##2 int_oe == $past(reg_wdata[MC_OUT2], 2) && op2_n_pin == !int_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("output enable wrong");
	property p_tx_loop;
		mc_wr && reg_wdata[MC_LOOP] |-> ##2 tx_pin;
	endproperty
	a_tx_loop: assert property (p_tx_loop) else $error("tx pin not idle in loop");
	property p_div;
		s_div_wr |-> $countones({baud_tick, $past(baud_tick), $past(baud_tick, 2),
			$past(baud_tick, 3)}) == 1;
	endproperty
	a_div: assert property (p_div) else $error("divided tick rate wrong");
	property p_fast;
		s_fast_wr |-> baud_tick;
	endproperty
	a_fast: assert property (p_fast) else $error("undivided tick missing");
	property p_msr_gate;
		!interrupt_enable_reg[3] |=> !int_msr_req;
	endproperty
	a_msr_gate: assert property (p_msr_gate) else $error("modem request ungated");
	property p_msr_int;
		$past(reg_rd && reg_addr == OFS_MODEM_STATUS && interrupt_enable_reg[3])
			&& reg_rdata[3:0] != 4'h0 |-> int_msr_req;
	endproperty
	a_msr_int: assert property (p_msr_int) else $error("modem request missing");
	property p_full;
		rx_char_done && rx_fifo_level >= RX_DEPTH |=> !rx_push;
	endproperty
	a_full: assert property (p_full) else $error("push into full fifo");
	property p_lsr_rx;
		ls_rd |=> reg_rdata[0] == ($past(rx_fifo_level) != 6'h00) && reg_rdata[4:2] ==
			($past(rx_fifo_level) != 6'h00 ? 3'($past(rx_top_flags)) : 3'h0);
	endproperty
	a_lsr_rx: assert property (p_lsr_rx) else $error("rx status wrong");
	property p_lsr_tx;
		ls_rd |=> reg_rdata[6] == ($past(tx_shift_empty) && reg_rdata[5])
			&& (!reg_rdata[7] || $past(rx_fifo_any_err));
	endproperty
	a_lsr_tx: assert property (p_lsr_tx) else $error("tx or error status wrong");
endmodule
bind uml_modem_line_status_flow uml_mlsf_properties u_props (.core_clk, .reset, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dtr_n_pin, .op2_n_pin, .tx_pin, .int_oe,
	.baud_tick, .interrupt_enable_reg, .tx_shift_empty, .rx_fifo_level, .rx_top_flags,
	.rx_fifo_any_err, .rx_char_done, .rx_push, .int_msr_req);
`default_nettype wire

// *** sim/uml_modem_line_status_flow_bench.sv ***
// Purpose: self-checking bench for the modem, line status and flow block
// Assumes: the peer model drives the handshake pins, the bench plays host and core
// Notes: register reads are checked against notes queued by the read task
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module uml_modem_line_status_flow_bench;
	import uml_pkg::*;
	logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, tx_serial = 0;
	logic tx_hold_moved = 0, tx_host_load = 0, tx_shift_empty = 0, rx_fifo_any_err = 0;
	logic rx_char_done = 0, cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin, rx_pin, rts_n_pin;
	logic dtr_n_pin, op2_n_pin, tx_pin, int_oe, rx_serial, baud_tick, tx_stop, rx_push;
	logic int_msr_req, int_rx_trig_req, rx_push_brk, int_thr_req;
	logic rx_break_frame = 0, tx_fifo_emptied = 0;
	logic [2:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata, v, e, m, exp_q[$], msk_q[$];
	logic [7:0] n, ls;
	logic [3:0] interrupt_enable_reg = 0, set_lines = 4'hf, p, d;
	logic [5:0] rx_fifo_level = 0, lv;
	logic [5:0] tl[6] = '{TRIG_LOW0, TRIG_L0, TRIG_L1, TRIG_L2, TRIG_L3, RX_DEPTH};
	uml_rx_flags_type rx_top_flags = '0;
	int failures = 0, cmp_count = 0;
	integer seed = 32'h14f0;
	uml_modem_line_status_flow u_dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .cts_n_pin, .dsr_n_pin, .cd_n_pin, .ri_n_pin, .rx_pin, .rts_n_pin, .dtr_n_pin,
		.op2_n_pin, .tx_pin, .int_oe, .interrupt_enable_reg, .tx_serial, .rx_serial, .baud_tick,
		.tx_hold_moved, .tx_fifo_emptied, .tx_host_load, .tx_shift_empty, .tx_stop,
		.rx_fifo_level, .rx_top_flags, .rx_fifo_any_err, .rx_char_done, .rx_break_frame,
		.rx_push, .rx_push_brk, .int_thr_req, .int_msr_req, .int_rx_trig_req);
	uml_modem_peer u_peer (.core_clk, .set_lines, .tx_pin, .cd_n_pin, .ri_n_pin, .dsr_n_pin,
		.cts_n_pin, .rx_pin);
	// 250 MHz clock
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] w);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		cyc(1);
		reg_wr <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] k);
		exp_q.push_back(x);
		msk_q.push_back(k);
		reg_addr <= a;
		reg_rd <= 1'b1;
		cyc(1);
		reg_rd <= 1'b0;
		cyc(1);
	endtask
	task automatic lvl(input logic [5:0] x);
		rx_fifo_level <= x;
		cyc(4);
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// read answers stand one cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			`CHK(reg_rdata & m, e & m)
		end
		rd_d <= reg_rd;
	end
	// watchdog
	initial begin
		cyc(20000);
		failures++;
		finish_test;
	end
	// main sequence
	initial begin
		cyc(5);
		reset <= 1'b0;
		cyc(1);
		`CHK({rts_n_pin, dtr_n_pin, op2_n_pin, int_oe}, 4'he)
		v = 8'($random(seed));
		rd(OFS_ENH_FEATURE, 8'h00, 8'hff);
		wr(OFS_SCRATCH, v);
		rd(OFS_SCRATCH, v, 8'hff);
		wr(3'h6, v);
		rd(3'h6, 8'h00, 8'hff);
		for (int i = 0; i < 16; i++) begin
			wr(OFS_MODEM_CTRL, 8'(i));
			cyc(2);
			`CHK({rts_n_pin, dtr_n_pin, op2_n_pin, int_oe}, {~i[1], ~i[0], ~i[3], i[3]})
			rd(OFS_MODEM_CTRL, 8'(i), 8'hff);
		end
		rd(OFS_MODEM_STATUS, 8'h00, 8'hff);
		p = 4'hf;
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			interrupt_enable_reg <= {v[4], 3'h0};
			set_lines <= v[3:0];
			d = {p[3] ^ v[3], !p[2] & v[2], p[1] ^ v[1], p[0] ^ v[0]};
			cyc(8);
			`CHK(int_msr_req, v[4] & (d != 4'h0))
			rd(OFS_MODEM_STATUS, {~v[3:0], d}, 8'hff);
			rd(OFS_MODEM_STATUS, {~v[3:0], 4'h0}, 8'hff);
			p = v[3:0];
		end
		for (int i = 0; i < 16; i++) begin
			set_lines <= 4'($random(seed));
			tx_serial <= i[0];
			wr(OFS_MODEM_CTRL, 8'(16 + i));
			cyc(3);
			rd(OFS_MODEM_STATUS, {i[3], i[2], i[0], i[1], 4'h0}, 8'hf0);
			`CHK({tx_pin, rts_n_pin, dtr_n_pin, rx_serial}, {3'h7, i[0]})
		end
		wr(OFS_MODEM_CTRL, 8'h80);
		cyc(4);
		n = 8'h00;
		repeat (40) begin
			cyc(1);
			n += baud_tick;
		end
		`CHK(n, 8'(40 / CLK_DIV))
		for (int j = 0; j < 4; j++) begin
			wr(OFS_ENH_FEATURE, {j[1], 7'h0});
			set_lines <= {3'h7, j[0]};
			cyc(8);
			`CHK(tx_stop, j[1] & j[0])
		end
		wr(OFS_ENH_FEATURE, 8'h40);
		wr(OFS_MODEM_CTRL, 8'h02);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_FIFO_CTRL, {c[1:0], 6'h01});
			lvl(6'h00);
			lvl(tl[c + 1] - 6'h01);
			`CHK(int_rx_trig_req, 1'b0)
			lvl(tl[c + 1]);
			`CHK(int_rx_trig_req, 1'b1)
			lvl(tl[c + 2] - 6'h01);
			`CHK(rts_n_pin, 1'b0)
			lvl(tl[c + 2]);
			`CHK(rts_n_pin, 1'b1)
			lvl(tl[c]);
			`CHK(rts_n_pin, 1'b1)
			lvl(tl[c] - 6'h01);
			`CHK(rts_n_pin, 1'b0)
		end
		for (int j = 0; j < 2; j++) begin
			rx_fifo_level <= j[0] ? RX_DEPTH : 6'h00;
			rx_char_done <= 1'b1;
			cyc(1);
			rx_char_done <= 1'b0;
			cyc(1);
			`CHK(rx_push, !j[0])
			rd(OFS_LINE_STATUS, {6'h0, j[0], 1'b0}, 8'h02);
			rd(OFS_LINE_STATUS, 8'h00, 8'h02);
		end
		// break: one push per low spell, re-armed once the line idles high
		rx_fifo_level <= 6'h00;
		for (int j = 0; j < 3; j++) begin
			tx_serial <= (j == 2);
			cyc(8);
			rx_break_frame <= 1'b1;
			cyc(1);
			rx_break_frame <= 1'b0;
			cyc(1);
			`CHK(rx_push_brk, j != 1)
			`CHK({tx_pin, rx_serial}, {2{j == 2}})
		end
		// host load clears holding-empty; a move or fifo empty in the same cycle wins
		interrupt_enable_reg <= 4'h2;
		tx_shift_empty <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			tx_host_load <= 1'b1;
			tx_hold_moved <= j[0];
			tx_fifo_emptied <= j[1];
			cyc(1);
			{tx_host_load, tx_hold_moved, tx_fifo_emptied} <= 3'h0;
			cyc(2);
			`CHK(int_thr_req, j != 0)
			rd(OFS_LINE_STATUS, {1'b0, {2{j != 0}}, 5'h0}, 8'h60);
		end
		// random receive and transmit status; fifo mode on, holding empty, no overrun
		repeat (12) begin
			v = 8'($random(seed));
			lv = 6'($unsigned($random(seed)) % 33);
			rx_fifo_level <= lv;
			rx_top_flags <= v[2:0];
			rx_fifo_any_err <= v[3];
			tx_shift_empty <= v[4];
			cyc(1);
			ls = {v[3], v[4], 1'b1, ((lv != 6'h00) ? v[2:0] : 3'h0), 1'b0, lv != 6'h00};
			rd(OFS_LINE_STATUS, ls, 8'hff);
		end
		cyc(3);
		finish_test;
	end
endmodule
`default_nettype wire
